// >>> hdl/cmx_clock_ctrl.sv
`timescale 1ns/10ps
`include "cmx_cfg.svh"
// Register file and control for oscillator trim, clock multiplier and external drive
module cmx_clock_ctrl import cmx_pkg::*; #(
  parameter int LOCK_CYCLES = `CMX_LOCK_CYCLES,
  parameter int SETTLE_EDGES = `CMX_XTAL_SETTLE_EDGES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Special register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Factory calibration
  input wire logic [5:0] factory_fine_trim,
  // System clock source select from the selector register
  input wire logic [1:0] core_clock_source_select,
  // External oscillator amplitude detector level
  input wire logic osc_amp_level,
  // Analog and routing controls
  output logic [5:0] fine_trim,
  output logic mult_enable,
  output logic mult_use_ext,
  output logic mult_base_x4,
  output logic [2:0] mult_num,
  output logic [2:0] mult_den,
  output logic mult_locked,
  output logic mult_to_core_clock,
  output cmx_drive_t ext_drive,
  output logic [2:0] ext_drive_level
);
  ////////////////////////////////////////////////////////////////////////
  // Scaling decode: output = base * num / den
  // Ratio holds num in bits 5:3 and den in bits 2:0
  function automatic logic [5:0] scale_ratio(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h09;
    case (code)
      3'h0, 3'h1, 3'h2: r = 6'h09;
      3'h3: r = 6'h13;
      3'h4: r = 6'h14;
      3'h5: r = 6'h15;
      3'h6: r = 6'h16;
      3'h7: r = 6'h17;
      default: r = 6'h09;
    endcase
    return r;
  endfunction : scale_ratio

  // Crystal modes claim both pins; the one-pin modes claim the output pin only
  function automatic cmx_drive_t drive_decode(input cmx_drive_mode_t m);
    cmx_drive_t d;
    d = '0;
    case (m)
      CMX_DRV_XTAL: d = 5'b11110;
      CMX_DRV_XTAL_DIV2: d = 5'b11111;
      CMX_DRV_CMOS: d = 5'b01100;
      CMX_DRV_CMOS_DIV2: d = 5'b01101;
      CMX_DRV_RC, CMX_DRV_CAP: d = 5'b01100;
      default: d = '0;
    endcase
    return d;
  endfunction : drive_decode

  // One-hot register select, shared by the write strobes and the read mux
  function automatic logic [2:0] reg_select(input logic [7:0] addr);
    logic [2:0] s;
    s = 3'h0;
    case (addr)
      `CMX_ADDR_MULT_CTRL: s = 3'h1;
      `CMX_ADDR_FINE_TRIM: s = 3'h2;
      `CMX_ADDR_EXT_OSC: s = 3'h4;
      default: s = 3'h0;
    endcase
    return s;
  endfunction : reg_select

  ////////////////////////////////////////////////////////////////////////
  // Registers
  // One-hot multiplier state; LOCKING holds until the multiplier is disabled
  typedef enum logic [2:0] {
    CMX_ST_OFF = 3'b001,
    CMX_ST_ON = 3'b010,
    CMX_ST_LOCKING = 3'b100
  } cmx_mult_state_t;

  cmx_mult_state_t st_q, st_d;
  cmx_mult_ctrl_t mc_q, mc_d;
  cmx_ext_ctrl_t xc_q, xc_d;
  logic [5:0] trim_q, trim_d;
  logic trim_loaded_q;
  logic [7:0] rdata_q, rdata_d;
  logic lock_start, lock_running, lock_done, xtal_ok, ref_ok;
  logic [5:0] ratio;
  cmx_drive_t drv;
  cmx_drive_t drv_q;
  logic [5:0] trim_o_q;
  logic en_o_q, ext_o_q, x4_o_q, lock_o_q, route_o_q;
  logic [2:0] num_o_q, den_o_q, lvl_o_q;
  logic [5:0] trim_o_d;
  logic en_o_d, ext_o_d, x4_o_d, lock_o_d, route_o_d;
  logic [2:0] num_o_d, den_o_d, lvl_o_d;
  logic [2:0] reg_sel;

  ////////////////////////////////////////////////////////////////////////
  // Address decode; unmapped addresses select nothing, so writes to them are dropped
  assign reg_sel = reg_select(reg_addr);
  wire wr_mc = reg_wr && reg_sel[0];
  wire wr_ft = reg_wr && reg_sel[1];
  wire wr_xc = reg_wr && reg_sel[2];

  ////////////////////////////////////////////////////////////////////////
  // Multiplier control and state
  always_comb begin
    mc_d = mc_q;
    st_d = st_q;
    lock_start = 1'b0;
    if (wr_mc) begin
      mc_d.mult_enable = reg_wdata[`CMX_BIT_MULT_EN];
      mc_d.mult_scale = reg_wdata[4:2];
      mc_d.mult_input_select = reg_wdata[1:0];
    end
    // An initialise write is honoured only once enabled; from off it is dropped
    case (st_q)
      CMX_ST_OFF: begin
        if (mc_d.mult_enable) begin
          st_d = CMX_ST_ON;
        end
      end
      CMX_ST_ON: begin
        if (!mc_d.mult_enable) begin
          st_d = CMX_ST_OFF;
        end else if (wr_mc && reg_wdata[`CMX_BIT_MULT_INIT]) begin
          st_d = CMX_ST_LOCKING;
          lock_start = 1'b1;
        end
      end
      CMX_ST_LOCKING: begin
        if (!mc_d.mult_enable) begin
          st_d = CMX_ST_OFF;
        end else if (wr_mc && reg_wdata[`CMX_BIT_MULT_INIT]) begin
          lock_start = 1'b1;
        end
      end
      default: st_d = CMX_ST_OFF;
    endcase
    // Initialise reads one from the request until the multiplier is disabled
    mc_d.mult_initialise = (st_d == CMX_ST_LOCKING);
    mc_d.mult_locked = lock_done && mc_d.mult_enable;
  end

  // Lock timing only advances while the selected reference is usable
  assign ref_ok = !mc_q.mult_input_select[0] || (drv_q.drive_enable && (!drv_q.crystal_mode || xtal_ok));

  // Timer enable follows the next enable value, so a disabling write drops ready at once
  cmx_lock_timer #(.LOCK_CYCLES(LOCK_CYCLES)) u_lock (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(mc_d.mult_enable),
    .start(lock_start),
    .ref_ok(ref_ok),
    .running(lock_running),
    .locked(lock_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Fine trim and external oscillator control
  always_comb begin
    trim_d = trim_q;
    xc_d = xc_q;
    // Bits 7:6 of the trim register are not stored and read back as zero
    if (!trim_loaded_q) begin
      trim_d = factory_fine_trim;
    end else if (wr_ft) begin
      trim_d = reg_wdata[5:0];
    end
    if (wr_xc) begin
      xc_d.ext_drive_mode = cmx_drive_mode_t'(reg_wdata[6:4]);
      xc_d.ext_drive_level = reg_wdata[2:0];
    end
    // Bit 3 is forced low; the mode code is kept as written, reserved 001 included
    xc_d.rsvd = 1'b0;
    xc_d.crystal_valid = xtal_ok;
  end

  // Crystal-valid only counts in the two crystal modes and clears in any other
  cmx_xtal_detect #(.SETTLE_EDGES(SETTLE_EDGES)) u_xtal (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .crystal_mode(drv_q.crystal_mode),
    .osc_level(osc_amp_level),
    .valid(xtal_ok)
  );

  assign drv = drive_decode(xc_q.ext_drive_mode);
  assign ratio = scale_ratio(mc_q.mult_scale);

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered so it appears the cycle after the strobe
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_sel)
        3'h1: rdata_d = mc_q;
        3'h2: rdata_d = {2'h0, trim_q};
        3'h4: rdata_d = xc_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= CMX_ST_OFF;
      mc_q <= `CMX_RST_MULT_CTRL;
    end else begin
      st_q <= st_d;
      mc_q <= mc_d;
    end
  end

  // Factory trim is taken on the first edge after reset, so a late-settling fuse value still lands
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      xc_q <= `CMX_RST_EXT_OSC;
      trim_q <= 6'h00;
      trim_loaded_q <= 1'b0;
      drv_q <= '0;
    end else begin
      xc_q <= xc_d;
      trim_q <= trim_d;
      trim_loaded_q <= 1'b1;
      drv_q <= drv;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output flops; the analog multiplier forms f_out = f_in * base * num / den
  // Below the minimum input rate the analog core gives four-pulse bursts per input edge
  // Software must keep f_out at or under fifty megahertz; no range check is made here
  always_comb begin
    trim_o_d = trim_q;
    en_o_d = mc_q.mult_enable;
    ext_o_d = mc_q.mult_input_select[0];
    x4_o_d = mc_q.mult_input_select[1];
    num_o_d = ratio[5:3];
    den_o_d = ratio[2:0];
    lock_o_d = mc_q.mult_locked;
    // Routing waits for lock so the core never runs on an unsettled multiplier
    route_o_d = core_clock_source_select == `CMX_SRC_MULT && mc_q.mult_locked;
    lvl_o_d = xc_q.ext_drive_level;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trim_o_q <= 6'h00;
      en_o_q <= 1'b0;
      ext_o_q <= 1'b0;
      x4_o_q <= 1'b0;
      num_o_q <= 3'h1;
      den_o_q <= 3'h1;
      lock_o_q <= 1'b0;
      route_o_q <= 1'b0;
      lvl_o_q <= 3'h0;
    end else begin
      trim_o_q <= trim_o_d;
      en_o_q <= en_o_d;
      ext_o_q <= ext_o_d;
      x4_o_q <= x4_o_d;
      num_o_q <= num_o_d;
      den_o_q <= den_o_d;
      lock_o_q <= lock_o_d;
      route_o_q <= route_o_d;
      lvl_o_q <= lvl_o_d;
    end
  end

  // Every output is a flop copy; all but reg_rdata run one cycle behind register state, and reg_rdata holds the last read
  assign reg_rdata = rdata_q;
  assign fine_trim = trim_o_q;
  assign mult_enable = en_o_q;
  assign mult_use_ext = ext_o_q;
  assign mult_base_x4 = x4_o_q;
  assign mult_num = num_o_q;
  assign mult_den = den_o_q;
  assign mult_locked = lock_o_q;
  assign mult_to_core_clock = route_o_q;
  assign ext_drive = drv_q;
  assign ext_drive_level = lvl_o_q;
endmodule : cmx_clock_ctrl

// >>> hdl/cmx_cfg.svh
// Behaviour
// - Fine trim: bits 5:0 writable, 7:6 zero
// - Fine trim resets to factory calibration value
// - Output is two or four times input, then scaled
// - Input select picks source and x2/x4 base
// - Scale codes 000-010 one, else 2/n
// - Initialise reads zero until written; write starts locking; here only when the multiplier is already on, and it is dropped from off
// - Ready reads one only after lock settles
// - Slow input gives four-pulse bursts per edge
// - Output intended up to fifty megahertz
// - Crystal mode takes two pins, others one
// - Mode field selects drive type encoding
// - Crystal-valid set once crystal has settled
// - Source select 10 routes multiplier to core; here only once the multiplier is locked
`ifndef CMX_CFG_SVH
`define CMX_CFG_SVH
`define CMX_ADDR_MULT_CTRL 8'h97
`define CMX_ADDR_FINE_TRIM 8'h9E
`define CMX_ADDR_EXT_OSC 8'h9F
`define CMX_BIT_MULT_EN 7
`define CMX_BIT_MULT_INIT 6
`define CMX_BIT_MULT_LOCKED 5
`define CMX_BIT_XTAL_VALID 7
`define CMX_RST_MULT_CTRL 8'h00
`define CMX_RST_EXT_OSC 8'h00
`define CMX_SRC_MULT 2'h2
`define CMX_LOCK_TIME_NS 20000
`define CMX_CLK_PERIOD_NS 100
`define CMX_LOCK_CYCLES ((`CMX_LOCK_TIME_NS + `CMX_CLK_PERIOD_NS - 1) / `CMX_CLK_PERIOD_NS)
`define CMX_XTAL_SETTLE_EDGES 1024
`endif

// >>> hdl/cmx_pkg.sv
package cmx_pkg;
  typedef enum logic [2:0] {
    CMX_DRV_OFF = 3'h0,
    CMX_DRV_RSVD = 3'h1,
    CMX_DRV_CMOS = 3'h2,
    CMX_DRV_CMOS_DIV2 = 3'h3,
    CMX_DRV_RC = 3'h4,
    CMX_DRV_CAP = 3'h5,
    CMX_DRV_XTAL = 3'h6,
    CMX_DRV_XTAL_DIV2 = 3'h7
  } cmx_drive_mode_t;

  typedef struct packed {
    logic mult_enable;
    logic mult_initialise;
    logic mult_locked;
    logic [2:0] mult_scale;
    logic [1:0] mult_input_select;
  } cmx_mult_ctrl_t;

  typedef struct packed {
    logic crystal_valid;
    cmx_drive_mode_t ext_drive_mode;
    logic rsvd;
    logic [2:0] ext_drive_level;
  } cmx_ext_ctrl_t;

  typedef struct packed {
    logic osc_pin_in_claim;
    logic osc_pin_out_claim;
    logic drive_enable;
    logic crystal_mode;
    logic div2;
  } cmx_drive_t;
endpackage : cmx_pkg

// >>> hdl/cmx_lock_timer.sv
`timescale 1ns/10ps
`include "cmx_cfg.svh"
// Counts lock settling after an initialise request while enabled
module cmx_lock_timer import cmx_pkg::*; #(
  parameter int LOCK_CYCLES = `CMX_LOCK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic start,
  input wire logic ref_ok,
  // Status
  output logic running,
  output logic locked
);
  localparam int CW = $clog2(LOCK_CYCLES + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic run_q, run_d, lock_q, lock_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    lock_d = lock_q;
    if (!enable) begin
      cnt_d = '0;
      run_d = 1'b0;
      lock_d = 1'b0;
    end else if (start) begin
      cnt_d = '0;
      run_d = 1'b1;
      lock_d = 1'b0;
    end else if (run_q && ref_ok) begin
      if (cnt_q == CW'(LOCK_CYCLES - 1)) begin
        run_d = 1'b0;
        lock_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      lock_q <= lock_d;
    end
  end

  assign running = run_q;
  assign locked = lock_q;
endmodule : cmx_lock_timer

// >>> hdl/cmx_xtal_detect.sv
`timescale 1ns/10ps
`include "cmx_cfg.svh"
// Declares a crystal settled after enough amplitude-detector edges
module cmx_xtal_detect import cmx_pkg::*; #(
  parameter int SETTLE_EDGES = `CMX_XTAL_SETTLE_EDGES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic crystal_mode,
  input wire logic osc_level,
  // Status
  output logic valid
);
  localparam int CW = $clog2(SETTLE_EDGES + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic s1_q, s2_q, prev_q, valid_q, valid_d;

  // Two-stage synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      s1_q <= osc_level;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    valid_d = valid_q;
    if (!crystal_mode) begin
      cnt_d = '0;
      valid_d = 1'b0;
    end else if (s2_q && !prev_q && !valid_q) begin
      if (cnt_q == CW'(SETTLE_EDGES - 1)) begin
        valid_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      valid_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      valid_q <= valid_d;
    end
  end

  assign valid = valid_q;
endmodule : cmx_xtal_detect

// >>> dv/cmx_xtal_model.sv
`timescale 1ns/10ps
// Crystal seen through its amplitude detector
module cmx_xtal_model (
  // Drive from the block
  input wire logic run,
  // Detector level
  output logic osc
);
  initial osc = 1'b0;
  // Period unrelated to core_clk; stands low once the drive is off
  always begin
    #310;
    osc = run ? ~osc : 1'b0;
  end
endmodule : cmx_xtal_model

// >>> dv/cmx_clock_ctrl_assertions.sv
`timescale 1ns/10ps
module cmx_clock_ctrl_checker import cmx_pkg::*; #(
  parameter int LOCK_CYCLES = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Status
  input wire logic [1:0] core_clock_source_select,
  input wire logic mult_enable,
  input wire logic [2:0] mult_num,
  input wire logic [2:0] mult_den,
  input wire logic mult_locked,
  input wire logic mult_to_core_clock,
  input wire cmx_drive_t ext_drive
);
  localparam int LOCK_MAX = LOCK_CYCLES + 6;
  wire mc_wr = reg_wr && reg_addr == 8'h97;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  trim_top_zero_a: assert property (reg_rd && reg_addr == 8'h9E |=> reg_rdata[7:6] == 2'b00)
    else $error("trim top bits not zero");
  scale_pair_a: assert property (mult_num == 3'd1 ? mult_den == 3'd1 : mult_num == 3'd2 && mult_den >= 3'd3)
    else $error("bad scale factor");
  enable_on_a: assert property (mc_wr && reg_wdata[7] |-> ##2 mult_enable)
    else $error("enable not applied");
  enable_off_a: assert property (mc_wr && !reg_wdata[7] |-> ##2 !mult_enable && !mult_locked)
    else $error("disable left multiplier on");
  // Lock must not appear at once, yet within the settling bound
  lock_wait_a: assert property (mc_wr && reg_wdata[7:6] == 2'b11 && mult_enable && !mult_locked
    |-> !mult_locked [*4] ##[1:LOCK_MAX] mult_locked) else $error("lock timing wrong");
  locked_enabled_a: assert property (mult_locked |-> mult_enable)
    else $error("ready while disabled");
  core_route_a: assert property (mult_to_core_clock |->
    mult_locked && $past(core_clock_source_select) == 2'b10) else $error("route without lock or select");
  route_on_a: assert property (mult_locked && $past(core_clock_source_select) == 2'b10 |-> mult_to_core_clock)
    else $error("route missing");
  pin_claim_a: assert property (ext_drive.osc_pin_out_claim == ext_drive.drive_enable
    && ext_drive.osc_pin_in_claim == (ext_drive.drive_enable && ext_drive.crystal_mode)) else $error("pin claim");
  ext_off_a: assert property (reg_wr && reg_addr == 8'h9F && reg_wdata[6:5] == 2'b00 |-> ##2 !ext_drive.drive_enable)
    else $error("drive on in off mode");
endmodule : cmx_clock_ctrl_checker

bind cmx_clock_ctrl cmx_clock_ctrl_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk_i (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .core_clock_source_select(core_clock_source_select), .mult_enable(mult_enable), .mult_num(mult_num),
  .mult_den(mult_den), .mult_locked(mult_locked), .mult_to_core_clock(mult_to_core_clock), .ext_drive(ext_drive));

// >>> dv/cmx_clock_ctrl_test.sv
`timescale 1ns/10ps
module cmx_clock_ctrl_test import cmx_pkg::*; ;
  typedef struct packed {logic [7:0] addr, data, exp;} cmx_row_t;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_v;
  logic [1:0] core_clock_source_select = 2'b00;
  logic [5:0] fine_trim, factory_fine_trim = 6'h2B;
  logic osc_amp_level, mult_enable, mult_use_ext, mult_base_x4, mult_locked, mult_to_core_clock;
  logic [2:0] mult_num, mult_den, ext_drive_level;
  cmx_drive_t ext_drive;
  int errors = 0, checked = 0;
  // Init while disabled is dropped, reserved mode keeps bit 3 clear, unmapped reads zero
  cmx_row_t rows [7] = '{'{8'h9E, 8'hFF, 8'h3F}, '{8'h9E, 8'h15, 8'h15}, '{8'h97, 8'h7F, 8'h1F},
    '{8'h97, 8'h00, 8'h00}, '{8'h9F, 8'h1B, 8'h13}, '{8'h9F, 8'h00, 8'h00}, '{8'h42, 8'hAA, 8'h00}};

  initial forever #50 core_clk = ~core_clk;
  cmx_xtal_model xtal (.run(ext_drive.drive_enable), .osc(osc_amp_level));
  // Short counts keep the run brief
  cmx_clock_ctrl #(.LOCK_CYCLES(4), .SETTLE_EDGES(4)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .factory_fine_trim(factory_fine_trim), .core_clock_source_select(core_clock_source_select),
    .osc_amp_level(osc_amp_level), .fine_trim(fine_trim), .mult_enable(mult_enable), .mult_use_ext(mult_use_ext),
    .mult_base_x4(mult_base_x4), .mult_num(mult_num), .mult_den(mult_den), .mult_locked(mult_locked),
    .mult_to_core_clock(mult_to_core_clock), .ext_drive(ext_drive), .ext_drive_level(ext_drive_level));
  ////////////////////////////////////////
  task final_report;
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    rd_v = reg_rdata;
  endtask : rd
  // Bounded poll of one status bit
  task poll(input logic [7:0] a, input int b);
    int n;
    rd_v = 8'h00;
    for (n = 0; n < 100 && rd_v[b] !== 1'b1; n++) rd(a);
    if (rd_v[b] !== 1'b1) begin
      chk({7'h00, rd_v[b]}, 8'h01);
      final_report;
    end
  endtask : poll
  ////////////////////////////////////////
  initial begin
    repeat (5) @(negedge core_clk);
    chk({mult_enable, mult_locked, mult_to_core_clock, 2'b00, mult_den}, 8'h01);
    rst_n = 1'b1;
    rd(8'h9E);
    repeat (2) @(negedge core_clk);
    chk(rd_v, {2'b00, factory_fine_trim});
    chk({2'b00, fine_trim}, {2'b00, factory_fine_trim});
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].data);
      rd(rows[i].addr);
      chk(rd_v, rows[i].exp);
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h97, {3'b000, 3'(i), 2'(i)});
      repeat (2) @(negedge core_clk);
      chk({mult_use_ext, mult_base_x4, mult_num, mult_den}, {i[0], i[1], i < 3 ? 3'd1 : 3'd2, i < 3 ? 3'd1 : 3'(i)});
    end
    for (int m = 0; m < 8; m++) begin
      wr(8'h9F, {1'b0, 3'(m), 4'h0});
      repeat (2) @(negedge core_clk);
      chk({3'b000, ext_drive}, {3'b000, m >= 6, m >= 2, m >= 2, m >= 6, m == 3 || m == 7});
    end
    core_clock_source_select = 2'b10;
    wr(8'h97, 8'h00);
    wr(8'h97, 8'h0A);
    wr(8'h97, 8'h8A);
    repeat (51) @(negedge core_clk);
    rd(8'h97);
    chk(rd_v, 8'h8A);
    wr(8'h97, 8'hCA);
    poll(8'h97, 5);
    chk({mult_locked, mult_to_core_clock, rd_v[7:6], 4'h0}, 8'hF0);
    wr(8'h97, 8'h00);
    rd(8'h97);
    chk(rd_v | {mult_locked, mult_to_core_clock, 6'h00}, 8'h00);
    // Crystal must report settled before it may feed the multiplier
    wr(8'h9F, 8'h00);
    wr(8'h9F, 8'h67);
    rd(8'h9F);
    chk(rd_v, 8'h67);
    chk({5'h00, ext_drive_level}, 8'h07);
    poll(8'h9F, 7);
    wr(8'h97, 8'h00);
    wr(8'h97, 8'h01);
    wr(8'h97, 8'h81);
    repeat (51) @(negedge core_clk);
    wr(8'h97, 8'hC1);
    poll(8'h97, 5);
    chk({mult_use_ext, mult_locked, mult_to_core_clock, ext_drive}, 8'hFE);
    rst_n = 1'b0;
    repeat (5) @(negedge core_clk);
    chk({1'b0, mult_enable, mult_locked, ext_drive}, 8'h00);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    final_report;
  end
endmodule : cmx_clock_ctrl_test
